// ===== rtl/bridge_pkg.sv
// Function
// - suspend after more than 3 ms bus idle
// - host resume signalling leaves suspend
// - remote wake pulse when enabled; host resumes
// - four endpoints: control, interrupt, bulk out/in
// - route bulk out payload to the transmit FIFO; other endpoints' payload is dropped
// - transmit shift register, LSB first, baud paced
// - receive shift register, LSB first, baud paced
// - separate 128-byte transmit and receive FIFOs
// - NRZ: start, 8 data, parity, 1-2 stops
// - even, odd or no parity, generated and checked
// - power-on format is 8N1
// - power-on rate 9600, changeable from USB
// - rates 2400 to 3400000 within 0.84 percent
// - flag overrun and framing errors
// - event on character received and sent
// - receive pin falling edge wakes from suspend
// - flow control and remote wake configurable
// - host sets RTS/DTR, reads modem inputs
// - stored identifiers, strings, serial number
// - 256 bytes user memory, host read/write
// - CTS and RTS are active low
// - wait 16 oscillator periods after pin wake
package bridge_pkg;
	localparam longint CLK_HZ            = 100_000_000;
	localparam longint OSC_HZ            = 12_000_000;
	localparam longint BAUD_RESET_BPS    = 9600;
	// divisor is cycles per bit with four fraction bits
	localparam logic [19:0] BAUD_DIV_RESET =
		20'((CLK_HZ * 16 + BAUD_RESET_BPS / 2) / BAUD_RESET_BPS);
	localparam int     SUSPEND_TIME_MS   = 3;
	localparam int     SUSPEND_CYCLES_DEF = int'(SUSPEND_TIME_MS * (CLK_HZ / 1000));
	localparam longint STARTUP_OSC_PERIODS = 16;
	localparam logic [7:0] STARTUP_CYCLES =
		8'((STARTUP_OSC_PERIODS * CLK_HZ + OSC_HZ - 1) / OSC_HZ);
	localparam int     FIFO_DEPTH        = 128;
	localparam int     RTS_OFF_LEVEL     = 120;
	localparam int     RTS_ON_LEVEL      = 96;
	// synchroniser bit positions
	localparam int     SYN_RX            = 0;
	localparam int     SYN_CTS           = 1;
	localparam int     SYN_USB           = 5;
	localparam logic [5:0] SYNC_RESET    = 6'h1f;
	// endpoint numbers
	localparam logic [1:0] EP_CONTROL    = 2'h0;
	localparam logic [1:0] EP_INTERRUPT  = 2'h1;
	localparam logic [1:0] EP_BULK_OUT   = 2'h2;
	localparam logic [1:0] EP_BULK_IN    = 2'h3;
	// stored configuration memory layout
	localparam logic [8:0] MEM_USER_END  = 9'h0ff;
	localparam logic [8:0] MEM_VID_LO    = 9'h100;
	localparam logic [8:0] MEM_VID_HI    = 9'h101;
	localparam logic [8:0] MEM_PID_LO    = 9'h102;
	localparam logic [8:0] MEM_PID_HI    = 9'h103;
	localparam logic [8:0] MEM_MFR       = 9'h104;
	localparam logic [8:0] MEM_PRODUCT   = 9'h114;
	localparam logic [8:0] MEM_SERIAL    = 9'h134;
	localparam int         MEM_BYTES     = 316;

	typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} parity_type;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_type;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_type;
	typedef enum logic [1:0] {PWR_AWAKE, PWR_SUSPEND, PWR_STARTUP} pwr_state_type;
endpackage

// ===== rtl/byte_fifo_if.sv
`timescale 1ns/1ps
interface byte_fifo_if import bridge_pkg::*; #(parameter int DEPTH = FIFO_DEPTH);
	logic                     push_valid;
	logic                     push_ready;
	logic [7:0]               push_data;
	logic                     pop_valid;
	logic                     pop_ready;
	logic [7:0]               pop_data;
	logic [$clog2(DEPTH):0]   count;

	modport fifo (input push_valid, push_data, pop_ready,
		output push_ready, pop_valid, pop_data, count);
	modport user (output push_valid, push_data, pop_ready,
		input push_ready, pop_valid, pop_data, count);
endinterface

// ===== rtl/byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo import bridge_pkg::*; #(
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input  logic          clk,
	input  logic          rst_n,
	// both sides of the queue
	byte_fifo_if.fifo     port
);
	// depth must be a power of two so pointers wrap for free
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   count;
	} fifo_state_type;

	fifo_state_type r;
	fifo_state_type n;
	logic [7:0]     mem [DEPTH];
	logic           do_push;
	logic           do_pop;

	assign port.push_ready = (r.count != (AW+1)'(DEPTH));
	assign port.pop_valid  = (r.count != '0);
	assign port.pop_data   = mem[r.rp];
	assign port.count      = r.count;
	assign do_push = port.push_valid && port.push_ready;
	assign do_pop  = port.pop_ready && port.pop_valid;

	always_comb begin
		n = r;
		if (do_push) begin
			n.wp = r.wp + 1'b1;
		end
		if (do_pop) begin
			n.rp = r.rp + 1'b1;
		end
		n.count = r.count + (AW+1)'(do_push) - (AW+1)'(do_pop);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// storage carries no reset; only pointers define contents
	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[r.wp] <= port.push_data;
		end
	end
endmodule

// ===== rtl/uart_bridge_serial.sv
`timescale 1ns/1ps
module uart_bridge_serial import bridge_pkg::*; #(
	parameter int          SUSPEND_CYCLES = SUSPEND_CYCLES_DEF,
	parameter int          DEPTH          = FIFO_DEPTH,
	parameter logic [15:0] VID_RESET      = 16'h1a2b, // arbitrary value
	parameter logic [15:0] PID_RESET      = 16'h3c4d  // arbitrary value
) (
	// clock and reset
	input  logic        CORE_CLK,
	input  logic        RST_N,
	// serial pins
	input  logic        RX,
	output logic        TX,
	input  logic        CTS_N,
	output logic        RTS_N,
	input  logic        DSR_N,
	output logic        DTR_N,
	input  logic        DCD_N,
	input  logic        RI_N,
	// usb engine side: decoded payload stream
	input  logic        USB_BUS_ACTIVE,
	input  logic        USB_RX_VALID,
	input  logic [1:0]  USB_RX_EP,
	input  logic [7:0]  USB_RX_DATA,
	output logic        USB_RX_READY,
	output logic        BULK_IN_VALID,
	output logic [7:0]  BULK_IN_DATA,
	input  logic        BULK_IN_READY,
	output logic [3:0]  MODEM_STATUS,
	// line configuration from control endpoint
	input  logic        CFG_WRITE,
	input  logic [19:0] CFG_BAUD_DIV,
	input  logic [1:0]  CFG_PARITY,
	input  logic        CFG_TWO_STOP,
	input  logic        CFG_FLOW_EN,
	input  logic        CFG_WAKE_EN,
	input  logic        CFG_RTS,
	input  logic        CFG_DTR,
	// stored descriptor and user memory
	input  logic        MEM_WRITE,
	input  logic [8:0]  MEM_ADDR,
	input  logic [7:0]  MEM_WDATA,
	output logic [7:0]  MEM_RDATA,
	// status and events
	input  logic        ERR_CLEAR,
	output logic        RX_OVERRUN,
	output logic        RX_FRAME_ERROR,
	output logic        RX_PARITY_ERROR,
	output logic        RX_EVENT,
	output logic        TX_EVENT,
	output logic        SUSPENDED,
	output logic        REMOTE_WAKE
);
	typedef struct packed {
		logic [5:0]    s1;
		logic [5:0]    s2;
		logic [5:0]    s3;
		logic [5:0]    lvl;
		logic [19:0]   baud_div;
		parity_type    parity;
		logic          two_stop;
		logic          flow_en;
		logic          wake_en;
		logic          host_rts;
		logic          host_dtr;
		logic [15:0]   vendor_identifier;
		logic [15:0]   product_identifier;
		tx_state_type  tx_st;
		logic [7:0]    tx_sh;
		logic [2:0]    tx_bit;
		logic [15:0]   tx_cnt;
		logic [3:0]    tx_acc;
		logic          tx_par;
		logic          tx_stop2;
		logic          tx_pin;
		rx_state_type  rx_st;
		logic [7:0]    rx_sh;
		logic [2:0]    rx_bit;
		logic [15:0]   rx_cnt;
		logic [3:0]    rx_acc;
		logic          rx_par;
		logic          rx_stop2;
		logic          rx_prev;
		logic          rx_push;
		logic [7:0]    rx_byte;
		logic          overrun;
		logic          frame_err;
		logic          par_err;
		logic          rx_evt;
		logic          tx_evt;
		logic          ov0_v;
		logic          ov1_v;
		logic [7:0]    ob0;
		logic [7:0]    ob1;
		pwr_state_type pwr;
		logic [31:0]   idle_cnt;
		logic [7:0]    wake_cnt;
		logic          remote_wake;
		logic          rts_n;
		logic          dtr_n;
		logic [3:0]    modem;
		logic [7:0]    mem_rdata;
		logic          susp;
		logic          usb_rdy;
	} state_type;

	localparam state_type RST_STATE = '{
		s1: SYNC_RESET, s2: SYNC_RESET, s3: SYNC_RESET, lvl: SYNC_RESET,
		baud_div: BAUD_DIV_RESET, parity: PAR_NONE, vendor_identifier: VID_RESET, product_identifier: PID_RESET,
		tx_pin: 1'b1, rx_prev: 1'b1, rts_n: 1'b1, dtr_n: 1'b1, usb_rdy: 1'b1,
		tx_st: TX_IDLE, rx_st: RX_IDLE, pwr: PWR_AWAKE, default: '0};

	state_type  r;
	state_type  n;
	logic [7:0] mem [MEM_BYTES];
	logic       awake;
	logic       par_on;
	logic       rx_fall;
	logic       tx_go;
	logic       take;
	logic       bit_in;

	byte_fifo_if #(.DEPTH(DEPTH)) txf ();
	byte_fifo_if #(.DEPTH(DEPTH)) rxf ();

	byte_fifo #(.DEPTH(DEPTH)) tx_fifo (.clk(CORE_CLK), .rst_n(RST_N), .port(txf));
	byte_fifo #(.DEPTH(DEPTH)) rx_fifo (.clk(CORE_CLK), .rst_n(RST_N), .port(rxf));

	// fraction bits spread the remainder so fast rates stay accurate
	function automatic logic [19:0] bit_period(input logic [19:0] div, input logic [3:0] acc);
		logic [4:0] sum;
		sum = {1'b0, acc} + {1'b0, div[3:0]};
		bit_period = {div[19:4] + {15'h0000, sum[4]} - 16'h0001, sum[3:0]};
	endfunction

	assign awake   = (r.pwr == PWR_AWAKE);
	assign par_on  = (r.parity == PAR_EVEN) || (r.parity == PAR_ODD);
	assign rx_fall = r.rx_prev && !r.lvl[SYN_RX];
	assign tx_go   = (r.tx_st == TX_IDLE) && awake && (!r.flow_en || !r.lvl[SYN_CTS]);
	assign take    = r.ov0_v && BULK_IN_READY;
	assign bit_in  = r.lvl[SYN_RX];

	assign txf.push_valid = USB_RX_VALID && (USB_RX_EP == EP_BULK_OUT);
	assign txf.push_data  = USB_RX_DATA;
	assign txf.pop_ready  = tx_go;
	assign rxf.push_valid = r.rx_push;
	assign rxf.push_data  = r.rx_byte;
	assign rxf.pop_ready  = !r.ov1_v;

	always_comb begin
		n = r;
		n.s1  = {USB_BUS_ACTIVE, DCD_N, DSR_N, RI_N, CTS_N, RX};
		n.s2  = r.s1;
		n.s3  = r.s2;
		n.lvl = (r.s2 & r.s3) | (r.lvl & (r.s2 ^ r.s3));
		n.rx_prev     = r.lvl[SYN_RX];
		n.rx_push     = 1'b0;
		n.rx_evt      = 1'b0;
		n.tx_evt      = 1'b0;
		n.remote_wake = 1'b0;
		if (CFG_WRITE) begin
			n.baud_div = CFG_BAUD_DIV;
			n.parity   = parity_type'(CFG_PARITY);
			n.two_stop = CFG_TWO_STOP;
			n.flow_en  = CFG_FLOW_EN;
			n.wake_en  = CFG_WAKE_EN;
			n.host_rts = CFG_RTS;
			n.host_dtr = CFG_DTR;
		end
		// stored descriptor: identifier words in registers, strings in memory
		if (MEM_WRITE && MEM_ADDR == MEM_VID_LO) n.vendor_identifier[7:0] = MEM_WDATA;
		if (MEM_WRITE && MEM_ADDR == MEM_VID_HI) n.vendor_identifier[15:8] = MEM_WDATA;
		if (MEM_WRITE && MEM_ADDR == MEM_PID_LO) n.product_identifier[7:0] = MEM_WDATA;
		if (MEM_WRITE && MEM_ADDR == MEM_PID_HI) n.product_identifier[15:8] = MEM_WDATA;
		case (MEM_ADDR)
			MEM_VID_LO: n.mem_rdata = r.vendor_identifier[7:0];
			MEM_VID_HI: n.mem_rdata = r.vendor_identifier[15:8];
			MEM_PID_LO: n.mem_rdata = r.product_identifier[7:0];
			MEM_PID_HI: n.mem_rdata = r.product_identifier[15:8];
			default: n.mem_rdata = (MEM_ADDR < 9'(MEM_BYTES)) ? mem[MEM_ADDR] : 8'h00;
		endcase
		n.modem = ~r.lvl[4:1];
		n.dtr_n = ~r.host_dtr;
		if (!r.flow_en) begin
			n.rts_n = ~r.host_rts;
		end else if (rxf.count >= ($clog2(DEPTH)+1)'(RTS_OFF_LEVEL)) begin
			n.rts_n = 1'b1;
		end else if (rxf.count <= ($clog2(DEPTH)+1)'(RTS_ON_LEVEL)) begin
			n.rts_n = 1'b0;
		end
		// clear first so that a set in the same cycle wins
		if (ERR_CLEAR) begin
			n.overrun   = 1'b0;
			n.frame_err = 1'b0;
			n.par_err   = 1'b0;
		end
		if (r.rx_push && !rxf.push_ready) n.overrun = 1'b1;

		// power
		case (r.pwr)
			PWR_AWAKE: begin
				if (r.lvl[SYN_USB]) begin
					n.idle_cnt = '0;
				end else if (r.idle_cnt >= 32'(SUSPEND_CYCLES - 1)) begin
					n.pwr = PWR_SUSPEND;
				end else begin
					n.idle_cnt = r.idle_cnt + 32'h0000_0001;
				end
			end
			PWR_SUSPEND: begin
				n.idle_cnt = '0;
				if (r.lvl[SYN_USB]) begin
					n.pwr = PWR_AWAKE;
				end else if (rx_fall) begin
					n.pwr      = PWR_STARTUP;
					n.wake_cnt = STARTUP_CYCLES - 8'h01;
				end
			end
			PWR_STARTUP: begin
				if (r.lvl[SYN_USB]) begin
					n.pwr = PWR_AWAKE;
				end else if (r.wake_cnt != 8'h00) begin
					n.wake_cnt = r.wake_cnt - 8'h01;
				end else begin
					n.pwr         = PWR_AWAKE;
					n.remote_wake = r.wake_en;
				end
			end
			default: n.pwr = PWR_AWAKE;
		endcase

		// transmitter
		if (r.tx_st == TX_IDLE) begin
			if (txf.pop_valid && tx_go) begin
				n.tx_sh    = txf.pop_data;
				n.tx_par   = (^txf.pop_data) ^ (r.parity == PAR_ODD);
				n.tx_pin   = 1'b0;
				n.tx_bit   = 3'h0;
				n.tx_stop2 = 1'b0;
				{n.tx_cnt, n.tx_acc} = bit_period(r.baud_div, 4'h0);
				n.tx_st    = TX_START;
			end
		end else if (r.tx_cnt != 16'h0000) begin
			n.tx_cnt = r.tx_cnt - 16'h0001;
		end else begin
			{n.tx_cnt, n.tx_acc} = bit_period(r.baud_div, r.tx_acc);
			case (r.tx_st)
				TX_START: begin
					n.tx_st  = TX_DATA;
					n.tx_pin = r.tx_sh[0];
				end
				TX_DATA: begin
					n.tx_bit = r.tx_bit + 3'h1;
					n.tx_sh  = {1'b1, r.tx_sh[7:1]};
					n.tx_pin = r.tx_sh[1];
					if (r.tx_bit == 3'h7) begin
						n.tx_st  = par_on ? TX_PARITY : TX_STOP;
						n.tx_pin = par_on ? r.tx_par : 1'b1;
					end
				end
				TX_PARITY: begin
					n.tx_st  = TX_STOP;
					n.tx_pin = 1'b1;
				end
				TX_STOP: begin
					if (r.two_stop && !r.tx_stop2) begin
						n.tx_stop2 = 1'b1;
					end else begin
						n.tx_st  = TX_IDLE;
						n.tx_evt = 1'b1;
					end
				end
				default: n.tx_st = TX_IDLE;
			endcase
		end

		// receiver: sample at mid-bit after a half-bit start check
		if (r.rx_st == RX_IDLE) begin
			if (awake && rx_fall) begin
				n.rx_st    = RX_START;
				n.rx_cnt   = {1'b0, r.baud_div[19:5]};
				n.rx_acc   = 4'h0;
				n.rx_bit   = 3'h0;
				n.rx_par   = (r.parity == PAR_ODD);
				n.rx_stop2 = 1'b0;
			end
		end else if (r.rx_cnt != 16'h0000) begin
			n.rx_cnt = r.rx_cnt - 16'h0001;
		end else begin
			{n.rx_cnt, n.rx_acc} = bit_period(r.baud_div, r.rx_acc);
			case (r.rx_st)
				RX_START: n.rx_st = bit_in ? RX_IDLE : RX_DATA;
				RX_DATA: begin
					n.rx_sh  = {bit_in, r.rx_sh[7:1]};
					n.rx_par = r.rx_par ^ bit_in;
					n.rx_bit = r.rx_bit + 3'h1;
					if (r.rx_bit == 3'h7) n.rx_st = par_on ? RX_PARITY : RX_STOP;
				end
				RX_PARITY: begin
					if (r.rx_par ^ bit_in) n.par_err = 1'b1;
					n.rx_st = RX_STOP;
				end
				RX_STOP: begin
					if (!bit_in) n.frame_err = 1'b1;
					if (r.two_stop && !r.rx_stop2 && bit_in) begin
						n.rx_stop2 = 1'b1;
					end else begin
						n.rx_st   = RX_IDLE;
						n.rx_push = 1'b1;
						n.rx_byte = r.rx_sh;
						n.rx_evt  = 1'b1;
					end
				end
				default: n.rx_st = RX_IDLE;
			endcase
		end

		// two-entry output buffer toward the bulk in endpoint
		if (take) begin
			n.ov0_v = r.ov1_v;
			n.ob0   = r.ob1;
			n.ov1_v = 1'b0;
		end
		if (rxf.pop_valid && rxf.pop_ready) begin
			if (!n.ov0_v) begin
				n.ov0_v = 1'b1;
				n.ob0   = rxf.pop_data;
			end else begin
				n.ov1_v = 1'b1;
				n.ob1   = rxf.pop_data;
			end
		end
		// ready tracks the fifo's next count so it matches push_ready
		n.susp    = (n.pwr != PWR_AWAKE);
		n.usb_rdy = (txf.count + ($clog2(DEPTH)+1)'(txf.push_valid && txf.push_ready)
			- ($clog2(DEPTH)+1)'(txf.pop_valid && tx_go)) != ($clog2(DEPTH)+1)'(DEPTH);
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			r <= RST_STATE;
		end else begin
			r <= n;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (MEM_WRITE && MEM_ADDR < 9'(MEM_BYTES)) begin
			mem[MEM_ADDR] <= MEM_WDATA;
		end
	end

	assign TX              = r.tx_pin;
	assign RTS_N           = r.rts_n;
	assign DTR_N           = r.dtr_n;
	assign USB_RX_READY    = r.usb_rdy;
	assign BULK_IN_VALID   = r.ov0_v;
	assign BULK_IN_DATA    = r.ob0;
	assign MODEM_STATUS    = r.modem;
	assign MEM_RDATA       = r.mem_rdata;
	assign RX_OVERRUN      = r.overrun;
	assign RX_FRAME_ERROR  = r.frame_err;
	assign RX_PARITY_ERROR = r.par_err;
	assign RX_EVENT        = r.rx_evt;
	assign TX_EVENT        = r.tx_evt;
	assign SUSPENDED       = r.susp;
	assign REMOTE_WAKE     = r.remote_wake;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	chk_idle_line_high: assert property ((r.tx_st == TX_IDLE) |-> TX)
		else $error("transmit line not idle high");
	chk_start_bit_low: assert property ($rose(r.tx_st == TX_START) |-> !TX [*2])
		else $error("start bit not low");
	chk_idle_suspend: assert property (awake && !r.lvl[SYN_USB]
		&& r.idle_cnt == 32'(SUSPEND_CYCLES - 1) |=> SUSPENDED)
		else $error("no suspend after bus idle");
	chk_resume_wakes: assert property ((r.pwr == PWR_SUSPEND) && r.lvl[SYN_USB]
		|=> !SUSPENDED)
		else $error("resume did not wake");
	chk_startup_hold: assert property ((r.pwr == PWR_STARTUP) && r.wake_cnt != 8'h00
		&& !r.lvl[SYN_USB] |=> SUSPENDED)
		else $error("left startup wait early");
	chk_remote_wake_en: assert property (REMOTE_WAKE |-> $past(r.wake_en) && !SUSPENDED)
		else $error("remote wake without enable");
	chk_cts_blocks: assert property (r.flow_en && r.lvl[SYN_CTS] && r.tx_st == TX_IDLE
		|=> r.tx_st == TX_IDLE)
		else $error("character started while clear to send inactive");
	chk_rts_near_full: assert property (r.flow_en && !CFG_WRITE
		&& rxf.count >= ($clog2(DEPTH)+1)'(RTS_OFF_LEVEL) |=> RTS_N)
		else $error("request to send kept active near full");
	chk_overrun_flag: assert property (r.rx_push && !rxf.push_ready |=> RX_OVERRUN)
		else $error("overrun not flagged");
	chk_tx_event_idle: assert property (TX_EVENT |-> r.tx_st == TX_IDLE && TX)
		else $error("transmit event before frame end");
endmodule

// ===== verif/serial_peer.sv
`timescale 1ns/1ps
module serial_peer #(
	parameter int BIT_CYCLES = 40
) (
	// clock
	input  wire logic clk,
	// serial lines as the far device sees them
	input  wire logic tx_line,
	output logic      rx_line,
	output logic      cts_n
);
	logic       par_on;
	logic [9:0] got[$];
	logic [9:0] frame;

	initial begin
		rx_line = 1'b1;
		cts_n   = 1'b0; // low grants sending
		par_on  = 1'b0;
	end

	// mid-bit sampling; only the first stop bit is looked at
	always begin
		@(negedge tx_line);
		repeat (BIT_CYCLES / 2) @(posedge clk);
		frame = 10'h000;
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYCLES) @(posedge clk);
			frame[i] = tx_line;
		end
		if (par_on) begin
			repeat (BIT_CYCLES) @(posedge clk);
			frame[8] = tx_line;
		end
		repeat (BIT_CYCLES) @(posedge clk);
		frame[9] = tx_line;
		got.push_back(frame);
	end

	task automatic send(input logic [7:0] d, input logic [1:0] par,
			input logic bad_par, input logic bad_stop);
		rx_line = 1'b0;
		repeat (BIT_CYCLES) @(negedge clk);
		for (int i = 0; i < 8; i++) begin
			rx_line = d[i];
			repeat (BIT_CYCLES) @(negedge clk);
		end
		if (par != 2'h0) begin
			rx_line = (^d) ^ (par == 2'h2) ^ bad_par;
			repeat (BIT_CYCLES) @(negedge clk);
		end
		rx_line = ~bad_stop;
		repeat (BIT_CYCLES) @(negedge clk);
		rx_line = 1'b1;
		repeat (BIT_CYCLES) @(negedge clk);
	endtask
endmodule

// ===== verif/usb_uart_bridge_serial_side_tb_top.sv
`timescale 1ns/1ps
module usb_uart_bridge_serial_side_tb_top import bridge_pkg::*; ;
	logic        core_clk, rst_n, rx, tx, cts_n, rts_n, dsr_n, dtr_n, dcd_n, ri_n;
	logic        bus_act, usb_valid, usb_ready, bulk_valid, bulk_ready;
	logic [1:0]  usb_ep, cfg_par;
	logic [7:0]  usb_data, bulk_data, mem_wdata, mem_rdata;
	logic [3:0]  modem;
	logic [19:0] cfg_div;
	logic        cfg_wr, cfg_two, cfg_flow, cfg_wake, cfg_rts, cfg_dtr, mem_wr;
	logic [8:0]  mem_addr;
	logic        err_clr, ovr, ferr, perr, rx_ev, tx_ev, susp, rwake;
	int          fails, checks_done, rx_evs, tx_evs, n;

	uart_bridge_serial #(.SUSPEND_CYCLES(50)) dut_u (
		.CORE_CLK(core_clk), .RST_N(rst_n), .RX(rx), .TX(tx), .CTS_N(cts_n),
		.RTS_N(rts_n), .DSR_N(dsr_n), .DTR_N(dtr_n), .DCD_N(dcd_n), .RI_N(ri_n),
		.USB_BUS_ACTIVE(bus_act), .USB_RX_VALID(usb_valid), .USB_RX_EP(usb_ep),
		.USB_RX_DATA(usb_data), .USB_RX_READY(usb_ready), .BULK_IN_VALID(bulk_valid),
		.BULK_IN_DATA(bulk_data), .BULK_IN_READY(bulk_ready), .MODEM_STATUS(modem),
		.CFG_WRITE(cfg_wr), .CFG_BAUD_DIV(cfg_div), .CFG_PARITY(cfg_par),
		.CFG_TWO_STOP(cfg_two), .CFG_FLOW_EN(cfg_flow), .CFG_WAKE_EN(cfg_wake),
		.CFG_RTS(cfg_rts), .CFG_DTR(cfg_dtr), .MEM_WRITE(mem_wr), .MEM_ADDR(mem_addr),
		.MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata), .ERR_CLEAR(err_clr),
		.RX_OVERRUN(ovr), .RX_FRAME_ERROR(ferr), .RX_PARITY_ERROR(perr),
		.RX_EVENT(rx_ev), .TX_EVENT(tx_ev), .SUSPENDED(susp), .REMOTE_WAKE(rwake));

	serial_peer #(.BIT_CYCLES(40)) peer_u (
		.clk(core_clk), .tx_line(tx), .rx_line(rx), .cts_n(cts_n));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	always @(negedge core_clk) begin
		if (rx_ev === 1'b1) rx_evs++;
		if (tx_ev === 1'b1) tx_evs++;
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic limit(input int cnt, input int lim);
		if (cnt >= lim) begin
			fails++;
			$display("wrong value wait limit expected %0d seen %0d", lim, cnt);
			final_report();
		end
	endtask

	// 40 cycles a bit after every cfg call, so a frame stays short; t_defaults runs at the reset rate
	task automatic cfg(input logic [1:0] par, input logic two, flow, wake, rts, dtr);
		{cfg_div, cfg_par, cfg_two, cfg_flow} = {20'h0_0280, par, two, flow};
		{cfg_wake, cfg_rts, cfg_dtr, cfg_wr} = {wake, rts, dtr, 1'b1};
		@(negedge core_clk);
		cfg_wr = 1'b0;
		peer_u.par_on = (par == 2'h1 || par == 2'h2);
	endtask

	// leaves valid up so bytes can follow back to back
	task automatic usb_put(input logic [1:0] ep, input logic [7:0] d);
		{usb_valid, usb_ep, usb_data} = {1'b1, ep, d};
		for (n = 0; usb_ready !== 1'b1 && n < 300; n++) @(negedge core_clk);
		limit(n, 300);
		@(negedge core_clk);
	endtask

	task automatic get_tx(input logic [7:0] d, input logic p);
		logic [9:0] e;
		for (n = 0; peer_u.got.size() == 0 && n < 2000; n++) @(negedge core_clk);
		limit(n, 2000);
		e = peer_u.got.pop_front();
		check("tx data", e[7:0], d);
		check("tx parity", e[8], p);
		check("tx stop", e[9], 1'b1);
	endtask

	task automatic mem_acc(input logic w, input logic [8:0] a, input logic [7:0] d, exp);
		{mem_wr, mem_addr, mem_wdata} = {w, a, d};
		@(negedge core_clk);
		if (!w) check("mem read", mem_rdata, exp);
	endtask

	task automatic t_defaults();
		check("reset pins", {tx, rts_n, dtr_n, susp, usb_ready}, 5'h1d);
		usb_put(EP_BULK_OUT, 8'h01);
		usb_valid = 1'b0;
		for (n = 0; tx !== 1'b0 && n < 20; n++) @(negedge core_clk);
		limit(n, 20);
		for (n = 0; tx === 1'b0 && n < 11000; n++) @(negedge core_clk);
		check("start bit cycles", (n >= 10415 && n <= 10418), 1);
		rst_n = 1'b0;
		repeat (8) @(negedge core_clk);
		check("tx in reset", tx, 1'b1);
		rst_n = 1'b1;
		repeat (400) @(negedge core_clk);
		peer_u.got.delete();
	endtask

	task automatic t_tx();
		tx_evs = 0;
		cfg(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		usb_put(EP_CONTROL, 8'h33);
		usb_put(EP_INTERRUPT, 8'h44);
		usb_put(EP_BULK_OUT, 8'ha6);
		usb_put(EP_BULK_OUT, 8'h3c);
		usb_valid = 1'b0;
		get_tx(8'ha6, 1'b0);
		get_tx(8'h3c, 1'b0);
		repeat (60) @(negedge core_clk);
		check("tx events", tx_evs, 2);
		check("stray frames", peer_u.got.size(), 0);
		for (int k = 1; k < 3; k++) begin
			cfg(k[1:0], 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
			usb_put(EP_BULK_OUT, 8'h5b);
			usb_valid = 1'b0;
			get_tx(8'h5b, (k == 1));
		end
	endtask

	task automatic t_rx();
		rx_evs = 0;
		bulk_ready = 1'b0;
		cfg(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		peer_u.send(8'h5a, 2'h0, 1'b0, 1'b0);
		peer_u.send(8'ha5, 2'h0, 1'b0, 1'b0);
		check("rx events", rx_evs, 2);
		check("bulk first", {bulk_valid, bulk_data}, 9'h15a);
		bulk_ready = 1'b1;
		@(negedge core_clk);
		check("bulk second", {bulk_valid, bulk_data}, 9'h1a5);
		@(negedge core_clk);
		check("bulk drained", bulk_valid, 1'b0);
	endtask

	task automatic t_err();
		for (int k = 1; k < 3; k++) begin
			cfg(k[1:0], 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
			peer_u.send(8'h96, k[1:0], 1'b0, 1'b0);
			check("good parity", {perr, ferr}, 2'h0);
			peer_u.send(8'h96, k[1:0], 1'b1, 1'b0);
			check("bad parity", {perr, ferr}, 2'h2);
			peer_u.send(8'h97, k[1:0], 1'b0, 1'b1);
			check("bad stop", ferr, 1'b1);
			err_clr = 1'b1;
			@(negedge core_clk);
			err_clr = 1'b0;
			check("cleared", {ovr, perr, ferr}, 3'h0);
		end
	endtask

	task automatic t_modem();
		cfg(2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		repeat (3) @(negedge core_clk);
		check("rts flow empty", rts_n, 1'b0);
		peer_u.cts_n = 1'b1;
		repeat (6) @(negedge core_clk);
		usb_put(EP_BULK_OUT, 8'h71);
		usb_valid = 1'b0;
		n = 0;
		repeat (200) begin
			@(negedge core_clk);
			if (tx === 1'b0) n++;
		end
		check("blocked low bits", n, 0);
		peer_u.cts_n = 1'b0;
		for (n = 0; tx !== 1'b0 && n < 20; n++) @(negedge core_clk);
		peer_u.cts_n = 1'b1;
		get_tx(8'h71, 1'b0);
		peer_u.cts_n = 1'b0;
		cfg(2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
		dsr_n = 1'b0;
		repeat (8) @(negedge core_clk);
		check("rts dtr", {rts_n, dtr_n}, 2'h0);
		check("modem status", modem, 4'h5);
		{dsr_n, ri_n, dcd_n} = 3'h4;
		repeat (8) @(negedge core_clk);
		check("modem ring carrier", modem, 4'hb);
	endtask

	// fills buffer and fifo, then one more byte must overrun
	task automatic t_full();
		bulk_ready = 1'b0;
		cfg(2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		for (int k = 0; k < 131; k++) peer_u.send(k[7:0], 2'h0, 1'b0, 1'b0);
		check("rts near full", rts_n, 1'b1);
		check("overrun", ovr, 1'b1);
		check("head kept", {bulk_valid, bulk_data}, 9'h100);
		{bulk_ready, err_clr} = 2'h3;
		repeat (200) @(negedge core_clk);
		err_clr = 1'b0;
		check("drained", {rts_n, bulk_valid, ovr}, 3'h0);
	endtask

	task automatic t_mem();
		mem_acc(1'b1, MEM_VID_HI, 8'he7, 8'h00);
		mem_acc(1'b0, MEM_VID_HI, 8'h00, 8'he7);
		mem_acc(1'b1, 9'h0ff, 8'h5c, 8'h00);
		mem_acc(1'b0, 9'h0ff, 8'h00, 8'h5c);
		mem_acc(1'b1, 9'h13c, 8'h99, 8'h00);
		mem_acc(1'b0, 9'h13c, 8'h00, 8'h00);
	endtask

	// serial traffic has all ended by now
	task automatic t_power();
		cfg(2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		bus_act = 1'b0;
		for (n = 0; susp !== 1'b1 && n < 200; n++) @(negedge core_clk);
		check("suspend delay", (n >= 50 && n <= 60), 1);
		bus_act = 1'b1;
		for (n = 0; susp !== 1'b0 && n < 10; n++) @(negedge core_clk);
		check("resume", susp, 1'b0);
		bus_act = 1'b0;
		for (n = 0; susp !== 1'b1 && n < 200; n++) @(negedge core_clk);
		limit(n, 200);
		fork
			peer_u.send(8'hff, 2'h0, 1'b0, 1'b0);
			begin
				for (n = 0; rwake !== 1'b1 && n < 400; n++) @(negedge core_clk);
				check("wake delay", (n >= STARTUP_CYCLES && n < 160), 1);
				check("awake", susp, 1'b0);
				bus_act = 1'b1;
			end
		join
	endtask

	initial begin
		{rst_n, bus_act, usb_valid, usb_ep, usb_data, bulk_ready} = {1'b0, 1'b1, 11'h000, 1'b1};
		{dsr_n, dcd_n, ri_n, cfg_wr, cfg_div, cfg_par} = {3'h7, 1'b0, 20'h0_0280, 2'h0};
		{cfg_two, cfg_flow, cfg_wake, cfg_rts, cfg_dtr} = 5'h00;
		{mem_wr, mem_addr, mem_wdata, err_clr} = {1'b0, 9'h000, 8'h00, 1'b0};
		{fails, checks_done, rx_evs, tx_evs} = {32'h0, 32'h0, 32'h0, 32'h0};
		repeat (8) @(negedge core_clk);
		rst_n = 1'b1;
		@(negedge core_clk);
		t_defaults();
		t_tx();
		t_rx();
		t_err();
		t_full();
		t_modem();
		t_mem();
		t_power();
		final_report();
	end
endmodule
